// ===== verilog/eil_top.sv
// external interrupt latch with wishbone register access
//
// Local design decisions: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - low pin latches request per sensitivity
// - vector fetch acknowledge clears the latch
// - writing one to ack clears latch
// - reset clears latch and sensitivity select
// - edge mode: acknowledge clears at once
// - level mode: needs acknowledge and pin high
// - level mode: pending while pin low
// - acknowledge leaves later edge detection intact
// - mask bit withholds request from CPU
// - pending flag read-only, ignores mask
// - serviced request loads fixed vector pair
// - CPU global mask also blocks request
// - break clear-enable lets ack clear latch
// - without clear-enable, break ack ignored
// - ack bit write-only, reads zero
// - mask bit read/write, reset clear
// - sensitivity bit read/write, reset clear
module eil_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [31:0] adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    input  wire logic        ext_irq_pin_n_i,
    input  wire logic        vec_fetch_i,
    input  wire logic        brk_state_i,
    input  wire logic        ccr_imask_i,
    output logic             cpu_irq_req_o,
    output logic [15:0]      vec_addr_o,
    output logic             vec_valid_o,
    output logic             irq_pending_o,
    output logic             irq_o
);
    eil_pkg::eil_wb_req_s wb;
    eil_pkg::eil_cpu_s    cpu;
    eil_pkg::eil_state_s  st_reg;
    eil_pkg::eil_state_s  st_next;
    logic                 ack_reg;
    logic                 wr_ctl;
    logic                 wr_evt;
    logic                 wr_msk;
    logic                 wr_brk;
    logic                 sw_ack;
    logic                 hw_ack;
    logic                 fall;
    logic                 set_latch;
    logic                 clr_latch;
    logic                 level_hold;
    logic                 pend_ack;
    logic [1:0]           evt_set;
    logic                 in_range;

    eil_wb_decode u_dec (
        .cyc_i      (cyc_i),
        .stb_i      (stb_i),
        .we_i       (we_i),
        .adr_i      (adr_i),
        .sel_i      (sel_i),
        .dat_i      (dat_i),
        .ack_busy_i (ack_reg),
        .req_o      (wb)
    );

    assign cpu.vec_fetch = vec_fetch_i;
    assign cpu.brk_state = brk_state_i;
    assign cpu.ccr_imask = ccr_imask_i;

    // strobes; all fields live in byte lane 0
    assign in_range = (adr_i[31:4] == 28'h000_0000);
    assign wr_ctl = wb.req & wb.we & wb.sel[0] & in_range
                    & (wb.adr == eil_pkg::OFF_STATUS_CONTROL);
    assign wr_evt = wb.req & wb.we & wb.sel[0] & in_range
                    & (wb.adr == eil_pkg::OFF_EVT_STATUS);
    assign wr_msk = wb.req & wb.we & wb.sel[0] & in_range
                    & (wb.adr == eil_pkg::OFF_EVT_MASK);
    assign wr_brk = wb.req & wb.we & wb.sel[0] & in_range
                    & (wb.adr == eil_pkg::OFF_BREAK_CTRL);

    always_comb begin
        st_next = st_reg;
        // two-stage synchroniser, edge seen on stage two only
        st_next.pin_ff1  = ext_irq_pin_n_i;
        st_next.pin_sync = st_reg.pin_ff1;
        st_next.pin_prev = st_reg.pin_sync;
        fall = st_reg.pin_prev & ~st_reg.pin_sync;

        // software ack, held off in break unless clear-enable set
        sw_ack = wr_ctl & wb.dat[eil_pkg::BIT_ACK]
                 & (~cpu.brk_state | st_reg.brk_clr_en);
        hw_ack = cpu.vec_fetch;

        // a falling edge is never blocked by acknowledge
        level_hold = st_reg.sens_sel & ~st_reg.pin_sync;
        set_latch = fall | level_hold;
        clr_latch = sw_ack | hw_ack;
        // in level mode, an ack taken while the pin is low is kept until the pin returns high
        pend_ack = clr_latch | st_reg.ack_seen;
        if (set_latch) begin
            st_next.latch = 1'b1;
        end else if (pend_ack) begin
            st_next.latch = 1'b0;
        end
        st_next.ack_seen = st_next.latch
                           & (st_reg.ack_seen | (clr_latch & level_hold));

        if (wr_ctl) begin
            st_next.sens_sel = wb.dat[eil_pkg::BIT_SENS_SEL];
            st_next.mask     = wb.dat[eil_pkg::BIT_MASK];
        end
        if (wr_brk) begin
            st_next.brk_clr_en = wb.dat[eil_pkg::BIT_BRK_CLR_EN];
        end
        st_next.ack = sw_ack;

        // block events: sticky, set beats write-one clear
        evt_set = '0;
        evt_set[eil_pkg::EVT_LATCHED] = set_latch & ~st_reg.latch;
        evt_set[eil_pkg::EVT_ACKED]   = st_reg.latch & ~st_next.latch;
        if (wr_evt) begin
            st_next.evt_stat = st_reg.evt_stat & ~wb.dat[eil_pkg::EVT_W-1:0];
        end
        st_next.evt_stat = st_next.evt_stat | evt_set;
        if (wr_msk) begin
            st_next.evt_mask = wb.dat[eil_pkg::EVT_W-1:0];
        end
        st_next.irq = |(st_next.evt_stat & st_next.evt_mask);

        // cpu request gated by local and global masks
        st_next.cpu_req = st_next.latch & ~st_next.mask & ~cpu.ccr_imask;
        // vector pair presented on service of unmasked request
        st_next.vec_valid = st_reg.cpu_req & cpu.vec_fetch;
        st_next.vec_addr  = eil_pkg::VEC_ADDR_HI;
        if (st_reg.vec_valid) begin
            st_next.vec_addr = eil_pkg::VEC_ADDR_LO;
        end

        // read mux, ack bit always reads zero
        st_next.rdat = '0;
        if (wb.req & ~wb.we & in_range) begin
            unique case (wb.adr)
                eil_pkg::OFF_STATUS_CONTROL: begin
                    st_next.rdat[eil_pkg::BIT_PENDING]  = st_reg.latch;
                    st_next.rdat[eil_pkg::BIT_ACK]      = 1'b0;
                    st_next.rdat[eil_pkg::BIT_MASK]     = st_reg.mask;
                    st_next.rdat[eil_pkg::BIT_SENS_SEL] = st_reg.sens_sel;
                end
                eil_pkg::OFF_EVT_STATUS: begin
                    st_next.rdat[eil_pkg::EVT_W-1:0] = st_reg.evt_stat;
                end
                eil_pkg::OFF_EVT_MASK: begin
                    st_next.rdat[eil_pkg::EVT_W-1:0] = st_reg.evt_mask;
                end
                eil_pkg::OFF_BREAK_CTRL: begin
                    st_next.rdat[eil_pkg::BIT_BRK_CLR_EN] = st_reg.brk_clr_en;
                end
                default: begin
                    st_next.rdat = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg            <= '0;
            // synchroniser keeps tracking, so a pin held low gives no false edge
            st_reg.pin_ff1    <= st_next.pin_ff1;
            st_reg.pin_sync   <= st_next.pin_sync;
            st_reg.pin_prev   <= st_next.pin_prev;
            st_reg.latch      <= 1'b0;
            st_reg.sens_sel   <= eil_pkg::RST_SENS;
            st_reg.mask       <= eil_pkg::RST_MASK;
            st_reg.brk_clr_en <= eil_pkg::RST_BRK_CLR;
            st_reg.evt_stat   <= eil_pkg::RST_EVT;
            st_reg.evt_mask   <= eil_pkg::RST_EVT;
            st_reg.ack        <= 1'b0;
            st_reg.vec_addr   <= eil_pkg::VEC_ADDR_HI;
            ack_reg           <= 1'b0;
        end else begin
            st_reg  <= st_next;
            // unmapped addresses are acked and read zero
            ack_reg <= wb.req;
        end
    end

    assign dat_o         = st_reg.rdat;
    assign ack_o         = ack_reg;
    assign cpu_irq_req_o = st_reg.cpu_req;
    assign vec_addr_o    = st_reg.vec_addr;
    assign vec_valid_o   = st_reg.vec_valid;
    assign irq_pending_o = st_reg.latch;
    assign irq_o         = st_reg.irq;
endmodule
`default_nettype wire

// ===== verilog/eil_pkg.sv
// shared constants and types for the external interrupt latch block
package eil_pkg;
    // register word byte offsets
    localparam logic [3:0] OFF_STATUS_CONTROL = 4'h0;
    localparam logic [3:0] OFF_EVT_STATUS     = 4'h4;
    localparam logic [3:0] OFF_EVT_MASK       = 4'h8;
    localparam logic [3:0] OFF_BREAK_CTRL     = 4'hC;
    // status/control field positions
    localparam int BIT_SENS_SEL  = 0;
    localparam int BIT_MASK      = 1;
    localparam int BIT_ACK       = 2;
    localparam int BIT_PENDING   = 3;
    // break control field position
    localparam int BIT_BRK_CLR_EN = 0;
    // event status field positions
    localparam int EVT_LATCHED   = 0;
    localparam int EVT_ACKED     = 1;
    localparam int EVT_W         = 2;
    // interrupt vector locations
    localparam logic [15:0] VEC_ADDR_HI = 16'hFFFA;
    localparam logic [15:0] VEC_ADDR_LO = 16'hFFFB;
    // reset values
    localparam logic        RST_SENS    = 1'b0;
    localparam logic        RST_MASK    = 1'b0;
    localparam logic        RST_BRK_CLR = 1'b0;
    localparam logic [1:0]  RST_EVT     = 2'h0;

    typedef struct packed {
        logic [3:0]  adr;
        logic        we;
        logic [3:0]  sel;
        logic [31:0] dat;
        logic        req;
    } eil_wb_req_s;

    typedef struct packed {
        logic        vec_fetch;
        logic        brk_state;
        logic        ccr_imask;
    } eil_cpu_s;

    typedef struct packed {
        logic        pin_ff1;
        logic        pin_sync;
        logic        pin_prev;
        logic        latch;
        logic        ack_seen;
        logic        sens_sel;
        logic        mask;
        logic        brk_clr_en;
        logic [1:0]  evt_stat;
        logic [1:0]  evt_mask;
        logic        ack;
        logic [31:0] rdat;
        logic        cpu_req;
        logic        irq;
        logic [15:0] vec_addr;
        logic        vec_valid;
    } eil_state_s;
endpackage

// ===== verilog/eil_wb_decode.sv
// wishbone classic slave front end: request decode and byte enables
`timescale 1ns/100ps
`default_nettype none
module eil_wb_decode (
    input  wire logic                 cyc_i,
    input  wire logic                 stb_i,
    input  wire logic                 we_i,
    input  wire logic [31:0]          adr_i,
    input  wire logic [3:0]           sel_i,
    input  wire logic [31:0]          dat_i,
    input  wire logic                 ack_busy_i,
    output eil_pkg::eil_wb_req_s      req_o
);
    always_comb begin
        req_o.adr = adr_i[3:0];
        req_o.we  = we_i;
        req_o.sel = sel_i;
        req_o.dat = dat_i;
        // one access per request; ack_busy stops a second take before release
        req_o.req = cyc_i & stb_i & ~ack_busy_i;
    end
endmodule
`default_nettype wire

// ===== tb/eil_props.sv
// concurrent checks on the interrupt latch top ports
`timescale 1ns/100ps
`default_nettype none
module eil_props (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [31:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        ext_irq_pin_n_i,
    input wire logic        vec_fetch_i,
    input wire logic        ccr_imask_i,
    input wire logic        cpu_irq_req_o,
    input wire logic [15:0] vec_addr_o,
    input wire logic        vec_valid_o,
    input wire logic        irq_pending_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
    a_ack: assert property (p_ack) else $error("bus answer missing");
    property p_idle; !ack_o |-> dat_o == 32'h0000_0000; endproperty
    a_idle: assert property (p_idle) else $error("read data outside answer");
    property p_set; $fell(ext_irq_pin_n_i) |-> ##[1:5] irq_pending_o; endproperty
    a_set: assert property (p_set) else $error("fall not latched");
    property p_clr; ext_irq_pin_n_i [*4] ##0 vec_fetch_i |=> !irq_pending_o; endproperty
    a_clr: assert property (p_clr) else $error("fetch kept latch");
    property p_req;
        cpu_irq_req_o |-> irq_pending_o && !$past(ccr_imask_i);
    endproperty
    a_req: assert property (p_req) else $error("request not gated");
    property p_vec;
        vec_valid_o |-> $past(vec_fetch_i && cpu_irq_req_o) && vec_addr_o == 16'hfffa
            ##1 vec_addr_o == 16'hfffb;
    endproperty
    a_vec: assert property (p_vec) else $error("vector pair wrong");
    property p_rd;
        ack_o && $past(!we_i && adr_i == 32'h0000_0000) |-> dat_o[2] == 1'b0
            && dat_o[3] == $past(irq_pending_o) && dat_o[31:4] == 28'h000_0000;
    endproperty
    a_rd: assert property (p_rd) else $error("status read wrong");
    property p_rst; $past(rst_i) |-> !irq_pending_o && !cpu_irq_req_o; endproperty
    a_rst: assert property (p_rst) else $error("reset left request");
    c_vec: cover property (vec_valid_o);
    c_req: cover property (cpu_irq_req_o);
    c_wr: cover property (ack_o && $past(we_i));
endmodule
bind eil_top eil_props u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o,
    .ack_o, .ext_irq_pin_n_i, .vec_fetch_i, .ccr_imask_i, .cpu_irq_req_o, .vec_addr_o,
    .vec_valid_o, .irq_pending_o);
`default_nettype wire

// ===== tb/eil_pin_src.sv
// external interrupt source on an active-low pin with pull-up
`timescale 1ns/100ps
`default_nettype none
module eil_pin_src (
    input  wire logic clk_i,
    input  wire logic assert_i,
    output var logic  pin_n_o
);
    // released pin rests at the pull-up level
    initial pin_n_o = 1'b1;
    always @(posedge clk_i) pin_n_o <= !assert_i;
endmodule
`default_nettype wire

// ===== tb/eil_tb_top.sv
// self-checking bench for the external interrupt latch
`timescale 1ns/100ps
`default_nettype none
module eil_tb_top;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic        vf = 0, brk = 0, cpu_condition_codes = 0, src = 0;
    logic [31:0] adr = 0, wd = 0, dat_o, rd;
    logic        ack_o, pin_n, req_o, vv_o, pend_o, irq_o;
    logic [15:0] va_o;
    int          error_cnt = 0, total_checks = 0, m;
    always #4 clk_i = ~clk_i;
    eil_pin_src src_m (.clk_i(clk_i), .assert_i(src), .pin_n_o(pin_n));
    eil_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(4'hf), .dat_i(wd), .dat_o(dat_o), .ack_o(ack_o),
        .ext_irq_pin_n_i(pin_n), .vec_fetch_i(vf), .brk_state_i(brk), .ccr_imask_i(cpu_condition_codes),
        .cpu_irq_req_o(req_o), .vec_addr_o(va_o), .vec_valid_o(vv_o),
        .irq_pending_o(pend_o), .irq_o(irq_o));
    task conclude;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task cn(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // one classic cycle; the idle edge first keeps cyc low between cycles
    task wb(input logic [31:0] a, input logic w, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        cyc <= 1; stb <= 1; adr <= a; we <= w; wd <= d;
        for (i = 0; i < 20 && ack_o !== 1'b1; i++) @(posedge clk_i);
        if (i == 20) begin chk(0, 1); conclude; end
        rd = dat_o;
        cyc <= 0; stb <= 0;
    endtask
    task rchk(input logic [31:0] a, input logic [31:0] e);
        wb(a, 0, 0);
        chk(rd, e);
    endtask
    task wpend(input logic e);
        int i;
        for (i = 0; i < 12 && pend_o !== e; i++) @(posedge clk_i);
        chk(pend_o, e);
        if (i == 12) conclude;
    endtask
    initial begin
        m = $urandom(32'hd12e_d4f1);
        cn(10);
        rst_i <= 0;
        cn(4);
        rchk(0, 0);
        rchk(32'hc, 0);
        rchk(32'h10, 0);
        m = $urandom & 3;
        wb(0, 1, m); rchk(0, m);
        wb(0, 1, 0);
        src <= 1; wpend(1);
        rchk(0, 8);
        cn($urandom_range(3, 0));
        wb(0, 1, 4); cn(2); chk(pend_o, 0);
        rchk(0, 0);
        src <= 0; cn(5); src <= 1; wpend(1);
        wb(0, 1, 2); cn(2); chk(req_o, 0);
        rchk(0, 32'ha);
        src <= 0; cpu_condition_codes <= 1; wb(0, 1, 0); cn(3); chk(req_o, 0);
        cpu_condition_codes <= 0; cn(3); chk(req_o, 1);
        vf <= 1; @(posedge clk_i); vf <= 0;
        @(posedge clk_i); chk(vv_o, 1); chk(va_o, 16'hfffa);
        @(posedge clk_i); chk(va_o, 16'hfffb); chk(pend_o, 0);
        // level mode, acknowledge before release then after
        wb(0, 1, 1); src <= 1; wpend(1);
        wb(0, 1, 5); cn(4); chk(pend_o, 1);
        src <= 0; cn(6); chk(pend_o, 0);
        src <= 1; wpend(1); src <= 0; cn(6); chk(pend_o, 1);
        wb(0, 1, 5); cn(2); chk(pend_o, 0);
        brk <= 1; wb(0, 1, 0); src <= 1; wpend(1); src <= 0;
        wb(0, 1, 4); cn(2); chk(pend_o, 1);
        wb(32'hc, 1, 1); wb(0, 1, 4); cn(2); chk(pend_o, 0);
        brk <= 0; cn(3); chk(pend_o, 0);
        wb(32'hc, 1, 0);
        wb(4, 1, 3); wb(8, 1, 1); src <= 1; wpend(1); cn(2); chk(irq_o, 1);
        rchk(4, 1); rchk(8, 1);
        wb(4, 1, 1); cn(2); chk(irq_o, 0);
        wb(8, 1, 0);
        // reset while the pin stays low in level mode
        wb(0, 1, 1); cn(3); rst_i <= 1; cn(10); rst_i <= 0; cn(6);
        chk(pend_o, 0);
        rchk(0, 0);
        src <= 0; cn(4);
        conclude;
    end
endmodule
`default_nettype wire
